// *** hw/irq_pkg.sv ***
package irq_pkg;
	// ==========================================
	// sources and their fixed order
	localparam int SRC_N = 9;
	localparam int IDX_W = 4;
	localparam logic [3:0] SRC_EXT_A = 4'h0;
	localparam logic [3:0] SRC_TIMER_A = 4'h1;
	localparam logic [3:0] SRC_TIMER_B = 4'h2;
	localparam logic [3:0] SRC_TIMER_C = 4'h3;
	localparam logic [3:0] SRC_SERIAL = 4'h4;
	localparam logic [3:0] SRC_PULSE = 4'h5;
	localparam logic [3:0] SRC_BASE_TICK = 4'h6;
	localparam logic [3:0] SRC_EXT_B = 4'h7;
	localparam logic [3:0] SRC_TOUCH = 4'h8;
	// bits 0,6,7,8 may leave stop; bits 0,1,2,6,7,8 clear on response
	localparam logic [8:0] WAKE_MASK = 9'h1c1;
	localparam logic [8:0] AUTO_CLR_MASK = 9'h1c7;
	// ==========================================
	// vectors
	localparam logic [15:0] VEC_EXT_A = 16'h0003;
	localparam logic [15:0] VEC_TIMER_A = 16'h000b;
	localparam logic [15:0] VEC_TIMER_B = 16'h001b;
	localparam logic [15:0] VEC_TIMER_C = 16'h002b;
	localparam logic [15:0] VEC_SERIAL = 16'h003b;
	localparam logic [15:0] VEC_PULSE = 16'h0043;
	localparam logic [15:0] VEC_BASE_TICK = 16'h004b;
	localparam logic [15:0] VEC_EXT_B = 16'h0053;
	localparam logic [15:0] VEC_TOUCH = 16'h005b;
	// ==========================================
	// register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_PRIORITY = 8'h08;
	localparam logic [7:0] OFS_EXT_SEL = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CLEAR = 8'h14;
	localparam logic [7:0] OFS_STATE = 8'h18;
	localparam int EXT_A_FALL_LSB = 0;
	localparam int EXT_A_RISE_LSB = 3;
	localparam int EXT_B_FALL_LSB = 8;
	localparam int EXT_B_RISE_LSB = 11;
	localparam logic RST_GLOBAL = 1'b0;
	localparam logic [8:0] RST_ENABLE = 9'h000;
	localparam logic [8:0] RST_PRIORITY = 9'h000;
	localparam logic [13:0] RST_EXT_SEL = 14'h0000;
	localparam logic [15:0] RST_VECTOR = 16'h0000;
	// ==========================================
	// service level, one-hot
	typedef enum logic [3:0] {
		SVC_NONE = 4'b0001,
		SVC_LOW = 4'b0010,
		SVC_HIGH = 4'b0100,
		SVC_NEST = 4'b1000
	} svc_t;

	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		logic [15:0] v;
		v = VEC_EXT_A;
		case (idx)
			SRC_TIMER_A: v = VEC_TIMER_A;
			SRC_TIMER_B: v = VEC_TIMER_B;
			SRC_TIMER_C: v = VEC_TIMER_C;
			SRC_SERIAL: v = VEC_SERIAL;
			SRC_PULSE: v = VEC_PULSE;
			SRC_BASE_TICK: v = VEC_BASE_TICK;
			SRC_EXT_B: v = VEC_EXT_B;
			SRC_TOUCH: v = VEC_TOUCH;
			default: v = VEC_EXT_A;
		endcase
		return v;
	endfunction : vector_of
endpackage : irq_pkg

// *** hw/ext_grp_if.sv ***
`timescale 1ns/1ps
interface ext_grp_if;
	logic [2:0] pin;
	logic [2:0] fall_sel;
	logic [2:0] rise_sel;
	logic hit;
	modport detector(input pin, input fall_sel, input rise_sel, output hit);
	modport owner(output pin, output fall_sel, output rise_sel, input hit);
endinterface : ext_grp_if

// *** hw/ext_edge_detect.sv ***
`timescale 1ns/1ps
module ext_edge_detect (
	input wire logic hclk,
	input wire logic hresetn,
	ext_grp_if.detector grp
);
	// ==========================================
	// three-stage pin capture
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] level_r;
	logic [2:0] level_nxt;
	logic hit_r;
	logic hit_nxt;
	wire [2:0] agree = ~(s2_r ^ s3_r);
	wire [2:0] rise_ev = agree & s2_r & ~level_r;
	wire [2:0] fall_ev = agree & ~s2_r & level_r;

	// a glitch shorter than two clocks never reaches level_r
	assign level_nxt = (level_r & ~agree) | (s2_r & agree);
	assign hit_nxt = |((rise_ev & grp.rise_sel) | (fall_ev & grp.fall_sel));
	assign grp.hit = hit_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			level_r <= 3'h0;
			hit_r <= 1'b0;
		end else begin
			s1_r <= grp.pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
			hit_r <= hit_nxt;
		end
	end

	// ==========================================
	// checks
	a_edge_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(rise_ev & grp.rise_sel)) |=> grp.hit)
		else $error("selected rising edge gave no hit");
	a_fall_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(fall_ev & grp.fall_sel)) |=> grp.hit)
		else $error("selected falling edge gave no hit");
endmodule : ext_edge_detect

// *** hw/irq_ctrl.sv ***
// How it works
// - nine sources, each with one priority bit choosing high or low level.
// - a request reaches the cpu only with global and own enable set.
// - both external groups trigger on rising, falling or both edges.
// - each source hands the cpu its own fixed vector address.
// - equal-level requests are served in fixed order, group a first, touch last.
// - group a, base tick, group b and touch wake from stop; others never.
// - timer a and b flags set on overflow, clear when cpu responds.
// - timer c flag set on overflow, stays set until software clears it.
// - serial completion sets its flag; software clears it while servicing.
// - pulse period pass sets its flag; enable gates the request; software clears.
// - each group merges three pins, each with falling and rising select bits.
// - external flags set on trigger, cleared by hardware on response.
// - every source owns its enable, flag, priority bit and vector.
// - high preempts low, never equal; one instruction runs after return first.
// - requests during a service stay pending and are served afterwards.
`timescale 1ns/1ps
module irq_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [2:0] ext_group_a,
	input wire logic [2:0] ext_group_b,
	input wire logic timer_a_overflow,
	input wire logic timer_b_overflow,
	input wire logic timer_c_overflow,
	input wire logic serial_done,
	input wire logic pulse_period_pass,
	input wire logic base_tick,
	input wire logic touch_overflow,
	output logic cpu_irq_req,
	output logic [15:0] cpu_irq_vector,
	output logic cpu_irq_high,
	input wire logic cpu_ack,
	input wire logic cpu_reti,
	input wire logic cpu_instr_done,
	output logic stop_wake,
	output logic irq
);
	// ==========================================
	// state
	logic global_irq_enable_r;
	logic [8:0] enable_r;
	logic [8:0] priority_r;
	logic [13:0] ext_sel_r;
	logic [8:0] flags_r;
	logic [8:0] flags_nxt;
	irq_pkg::svc_t svc_r;
	irq_pkg::svc_t svc_nxt;
	logic req_r;
	logic req_nxt;
	logic [3:0] sel_idx_r;
	logic [3:0] sel_idx_nxt;
	logic lvl_r;
	logic lvl_nxt;
	logic [15:0] vec_r;
	logic block_r;
	logic block_nxt;
	logic wr_pend_r;
	logic [7:0] waddr_r;
	logic [31:0] rdata_r;

	// lowest index wins: this is the fixed query order
	function automatic logic [4:0] pick_first(input logic [8:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = irq_pkg::SRC_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : pick_first

	// ==========================================
	// bus decode
	wire addr_phase = hsel & hready & htrans[1];
	wire [7:0] aofs = {haddr[7:2], 2'b00};
	wire wr_ctrl = wr_pend_r && (waddr_r == irq_pkg::OFS_CTRL);
	wire wr_enable = wr_pend_r && (waddr_r == irq_pkg::OFS_ENABLE);
	wire wr_prio = wr_pend_r && (waddr_r == irq_pkg::OFS_PRIORITY);
	wire wr_ext = wr_pend_r && (waddr_r == irq_pkg::OFS_EXT_SEL);
	wire clr_we = wr_pend_r && (waddr_r == irq_pkg::OFS_CLEAR);
	wire [8:0] sw_clr = clr_we ? hwdata[8:0] : 9'h000;
	wire [31:0] state_word = {20'h00000, block_r, lvl_r, req_r, 1'b0, sel_idx_r, svc_r};
	logic [31:0] rd_mux;

	always_comb begin
		case (aofs)
			irq_pkg::OFS_CTRL: rd_mux = {31'h00000000, global_irq_enable_r};
			irq_pkg::OFS_ENABLE: rd_mux = {23'h000000, enable_r};
			irq_pkg::OFS_PRIORITY: rd_mux = {23'h000000, priority_r};
			irq_pkg::OFS_EXT_SEL: rd_mux = {18'h00000, ext_sel_r};
			irq_pkg::OFS_STATUS: rd_mux = {23'h000000, flags_r};
			irq_pkg::OFS_STATE: rd_mux = state_word;
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			waddr_r <= 8'h00;
			rdata_r <= 32'h00000000;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			waddr_r <= aofs;
			rdata_r <= (addr_phase & ~hwrite) ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_irq_enable_r <= irq_pkg::RST_GLOBAL;
			enable_r <= irq_pkg::RST_ENABLE;
			priority_r <= irq_pkg::RST_PRIORITY;
			ext_sel_r <= irq_pkg::RST_EXT_SEL;
		end else begin
			if (wr_ctrl) begin
				global_irq_enable_r <= hwdata[0];
			end
			if (wr_enable) begin
				enable_r <= hwdata[8:0];
			end
			if (wr_prio) begin
				priority_r <= hwdata[8:0];
			end
			if (wr_ext) begin
				ext_sel_r <= hwdata[13:0];
			end
		end
	end

	// ==========================================
	// external groups
	ext_grp_if grp_a_if();
	ext_grp_if grp_b_if();

	assign grp_a_if.pin = ext_group_a;
	assign grp_a_if.fall_sel = ext_sel_r[irq_pkg::EXT_A_FALL_LSB +: 3];
	assign grp_a_if.rise_sel = ext_sel_r[irq_pkg::EXT_A_RISE_LSB +: 3];
	assign grp_b_if.pin = ext_group_b;
	assign grp_b_if.fall_sel = ext_sel_r[irq_pkg::EXT_B_FALL_LSB +: 3];
	assign grp_b_if.rise_sel = ext_sel_r[irq_pkg::EXT_B_RISE_LSB +: 3];

	ext_edge_detect u_grp_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.grp(grp_a_if.detector)
	);

	ext_edge_detect u_grp_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.grp(grp_b_if.detector)
	);

	// ==========================================
	// flags
	wire take = cpu_ack & req_r;
	wire [8:0] sel_onehot = 9'h001 << sel_idx_r;
	wire [8:0] auto_clr = take ? (sel_onehot & irq_pkg::AUTO_CLR_MASK) : 9'h000;
	wire [8:0] set_ev = {touch_overflow, grp_b_if.hit, base_tick, pulse_period_pass,
		serial_done, timer_c_overflow, timer_b_overflow, timer_a_overflow, grp_a_if.hit};

	// set beats any clear in the same cycle, so nothing is lost
	assign flags_nxt = set_ev | (flags_r & ~(auto_clr | sw_clr));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_r <= 9'h000;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ==========================================
	// arbitration
	wire [8:0] cand = flags_r & enable_r & {9{global_irq_enable_r}};
	wire [4:0] hi_pick = pick_first(cand & priority_r);
	wire [4:0] lo_pick = pick_first(cand & ~priority_r);
	wire hi_busy = (svc_r == irq_pkg::SVC_HIGH) || (svc_r == irq_pkg::SVC_NEST);
	wire hi_ok = hi_pick[4] & ~hi_busy;
	wire lo_ok = lo_pick[4] & (svc_r == irq_pkg::SVC_NONE);

	// taking blocks one cycle so the same source is not offered twice
	assign req_nxt = (hi_ok | lo_ok) & ~block_r & ~take;
	assign sel_idx_nxt = hi_ok ? hi_pick[3:0] : lo_pick[3:0];
	assign lvl_nxt = hi_ok;
	assign block_nxt = cpu_reti | (block_r & ~cpu_instr_done);

	always_comb begin
		svc_nxt = svc_r;
		case (svc_r)
			irq_pkg::SVC_NONE: begin
				if (take) begin
					svc_nxt = lvl_r ? irq_pkg::SVC_HIGH : irq_pkg::SVC_LOW;
				end
			end
			irq_pkg::SVC_LOW: begin
				if (take && lvl_r) begin
					svc_nxt = irq_pkg::SVC_NEST;
				end else if (cpu_reti) begin
					svc_nxt = irq_pkg::SVC_NONE;
				end
			end
			irq_pkg::SVC_HIGH: begin
				if (cpu_reti) begin
					svc_nxt = irq_pkg::SVC_NONE;
				end
			end
			irq_pkg::SVC_NEST: begin
				if (cpu_reti) begin
					svc_nxt = irq_pkg::SVC_LOW;
				end
			end
			default: svc_nxt = irq_pkg::SVC_NONE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			svc_r <= irq_pkg::SVC_NONE;
			req_r <= 1'b0;
			sel_idx_r <= 4'h0;
			lvl_r <= 1'b0;
			vec_r <= irq_pkg::RST_VECTOR;
			block_r <= 1'b0;
		end else begin
			svc_r <= svc_nxt;
			req_r <= req_nxt;
			sel_idx_r <= sel_idx_nxt;
			lvl_r <= lvl_nxt;
			vec_r <= irq_pkg::vector_of(sel_idx_nxt);
			block_r <= block_nxt;
		end
	end

	assign cpu_irq_req = req_r;
	assign cpu_irq_vector = vec_r;
	assign cpu_irq_high = lvl_r;
	// wake ignores the global enable: stop must end even with the core masked
	assign stop_wake = |(flags_r & enable_r & irq_pkg::WAKE_MASK);
	assign irq = |(flags_r & enable_r);

	// ==========================================
	// checks
	a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!global_irq_enable_r |=> !cpu_irq_req)
		else $error("request raised with global enable clear");

	a_vector_match: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_irq_req |-> cpu_irq_vector == irq_pkg::vector_of(sel_idx_r))
		else $error("vector does not match offered source");

	a_offer_eligible: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_irq_req |-> $past(global_irq_enable_r)
			&& (|($past(enable_r) & $past(flags_r) & sel_onehot)))
		else $error("offered source was not eligible");

	a_timer_autoclr: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_TIMER_A && !timer_a_overflow)
			|=> !flags_r[irq_pkg::SRC_TIMER_A])
		else $error("timer a flag survived response");

	a_timer_c_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_TIMER_C && !clr_we)
			|=> flags_r[irq_pkg::SRC_TIMER_C] ##1 (flags_r[irq_pkg::SRC_TIMER_C] || $past(clr_we)))
		else $error("timer c flag cleared by response");

	a_serial_set: assert property (@(posedge hclk) disable iff (!hresetn)
		serial_done |=> flags_r[irq_pkg::SRC_SERIAL])
		else $error("serial completion lost");

	a_pulse_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(pulse_period_pass ##1 !enable_r[irq_pkg::SRC_PULSE]) |-> flags_r[irq_pkg::SRC_PULSE]
			##1 !(cpu_irq_req && sel_idx_r == irq_pkg::SRC_PULSE))
		else $error("pulse flag or gating wrong");

	a_ext_autoclr: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_EXT_A && !grp_a_if.hit)
			|=> !flags_r[irq_pkg::SRC_EXT_A])
		else $error("group a flag survived response");

	a_no_equal_preempt: assert property (@(posedge hclk) disable iff (!hresetn)
		(svc_r == irq_pkg::SVC_LOW && cpu_irq_req) |-> cpu_irq_high)
		else $error("low request offered during low service");

	a_one_instr: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_reti |=> ##1 !cpu_irq_req)
		else $error("request offered right after return");

	a_wake_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		(timer_a_overflow && !(|(flags_nxt & irq_pkg::WAKE_MASK))) |=> !stop_wake)
		else $error("timer a woke the system");

	a_high_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		hi_busy |-> !cpu_irq_req)
		else $error("request offered during high service");

	a_nest_high: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && svc_r == irq_pkg::SVC_LOW) |-> cpu_irq_high)
		else $error("equal level nested into low service");

	a_low_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		(cpu_irq_req && !cpu_irq_high) |-> $past(svc_r) == irq_pkg::SVC_NONE)
		else $error("low request offered while busy");

	a_flag_held: assert property (@(posedge hclk) disable iff (!hresetn)
		(!take && !clr_we) |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("pending flag lost");

	a_timer_b_autoclr: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_TIMER_B && !timer_b_overflow)
			|=> !flags_r[irq_pkg::SRC_TIMER_B])
		else $error("timer b flag survived response");

	a_serial_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_SERIAL && !clr_we)
			|=> flags_r[irq_pkg::SRC_SERIAL])
		else $error("serial flag cleared by response");

	a_pulse_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_PULSE && !clr_we)
			|=> flags_r[irq_pkg::SRC_PULSE])
		else $error("pulse flag cleared by response");

	a_ext_b_autoclr: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && sel_idx_r == irq_pkg::SRC_EXT_B && !grp_b_if.hit)
			|=> !flags_r[irq_pkg::SRC_EXT_B])
		else $error("group b flag survived response");

	a_touch_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		(touch_overflow && enable_r[irq_pkg::SRC_TOUCH] && !wr_enable) |=> stop_wake)
		else $error("touch event did not wake");

	a_ext_b_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		(grp_b_if.hit && enable_r[irq_pkg::SRC_EXT_B] && !wr_enable) |=> stop_wake)
		else $error("group b event did not wake");
endmodule : irq_ctrl

// *** verif/cpu_model.sv ***
`timescale 1ns/1ps
module cpu_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic slow,
	input wire logic cpu_irq_req,
	output logic cpu_ack
);
	// ==========================================
	// takes every offer, at once or after a think time
	logic [1:0] lag_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lag_r <= 2'h0;
			cpu_ack <= 1'b0;
		end else begin
			// one-cycle ack, never repeated on a stale offer
			cpu_ack <= cpu_irq_req && !cpu_ack && lag_r == (slow ? 2'h3 : 2'h0);
			lag_r <= (cpu_irq_req && !cpu_ack) ? lag_r + 2'h1 : 2'h0;
		end
	end
endmodule : cpu_model

// *** verif/nine_source_interrupt_controller_test.sv ***
`timescale 1ns/1ps
module nine_source_interrupt_controller_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, cpu_irq_req, cpu_irq_high, stop_wake, irq, cpu_ack;
	logic [31:0] hrdata;
	logic [15:0] cpu_irq_vector;
	logic [2:0] grp_a = 3'h0;
	logic [2:0] grp_b = 3'h0;
	logic [8:0] ev = 9'h0;
	logic reti = 1'b0;
	logic idone = 1'b0;
	logic slow = 1'b1;
	logic [31:0] q;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [15:0] vec_tab [0:8] = '{16'h0003, 16'h000b, 16'h001b, 16'h002b, 16'h003b,
		16'h0043, 16'h004b, 16'h0053, 16'h005b};
	initial begin
		forever #10 hclk = ~hclk;
	end
	irq_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.ext_group_a(grp_a), .ext_group_b(grp_b), .timer_a_overflow(ev[1]),
		.timer_b_overflow(ev[2]), .timer_c_overflow(ev[3]), .serial_done(ev[4]),
		.pulse_period_pass(ev[5]), .base_tick(ev[6]), .touch_overflow(ev[8]),
		.cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector),
		.cpu_irq_high(cpu_irq_high), .cpu_ack(cpu_ack), .cpu_reti(reti),
		.cpu_instr_done(idone), .stop_wake(stop_wake), .irq(irq));
	cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.cpu_irq_req(cpu_irq_req), .cpu_ack(cpu_ack));
	// ==========================================
	// shared helpers, all entered just after a rising edge
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : xfer
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask : rd_chk
	// bounded wait; sel 0 watches the offer, 1 the wake line
	task automatic wait_on(input bit sel, input logic v);
		int i;
		i = 0;
		while (((sel ? stop_wake : cpu_irq_req) !== v) && i < 40) begin
			@(posedge hclk);
			i++;
		end
		chk(sel ? "stop_wake" : "cpu_irq_req", v, sel ? stop_wake : cpu_irq_req);
	endtask : wait_on
	task automatic pulse(input logic [8:0] m);
		ev <= m;
		@(posedge hclk);
		ev <= 9'h0;
		repeat (3) @(posedge hclk);
	endtask : pulse
	task automatic svc_end();
		reti <= 1'b1;
		@(posedge hclk);
		reti <= 1'b0;
		idone <= 1'b1;
		@(posedge hclk);
		idone <= 1'b0;
	endtask : svc_end
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge hclk);
			chk("held offer", 1'b0, cpu_irq_req);
		end
	endtask : quiet
	// offer, check vector and level, let the cpu take it
	task automatic taken(input int idx, input logic hi);
		wait_on(1'b0, 1'b1);
		chk("vector", vec_tab[idx], cpu_irq_vector);
		chk("level", hi, cpu_irq_high);
		wait_on(1'b0, 1'b0);
	endtask : taken
	// ==========================================
	// scenarios
	task automatic s_reset();
		rd_chk("status", irq_pkg::OFS_STATUS, 32'h0);
		rd_chk("ctrl", irq_pkg::OFS_CTRL, 32'h0);
		rd_chk("state", irq_pkg::OFS_STATE, 32'h1);
		xfer(1'b1, 8'h1c, 32'hffffffff);
		rd_chk("unmapped", 8'h1c, 32'h0);
		chk("hresp", 1'b0, hresp);
	endtask : s_reset
	task automatic s_gate();
		xfer(1'b1, irq_pkg::OFS_ENABLE, 32'h8);
		pulse(9'h028);
		chk("irq", 1'b1, irq);
		chk("offer global off", 1'b0, cpu_irq_req);
		chk("timer c wake", 1'b0, stop_wake);
		xfer(1'b1, irq_pkg::OFS_ENABLE, 32'h0);
		@(posedge hclk);
		chk("irq masked", 1'b0, irq);
		xfer(1'b1, irq_pkg::OFS_ENABLE, 32'h8);
		xfer(1'b1, irq_pkg::OFS_CTRL, 32'h1);
		taken(3, 1'b0);
		rd_chk("timer c kept", irq_pkg::OFS_STATUS, 32'h28);
		xfer(1'b1, irq_pkg::OFS_CLEAR, 32'h28);
		svc_end();
		@(posedge hclk);
		chk("irq cleared", 1'b0, irq);
	endtask : s_gate
	// every pulse source at once, served one by one in fixed order
	task automatic s_order();
		xfer(1'b1, irq_pkg::OFS_ENABLE, 32'h1ff);
		pulse(9'h17e);
		for (int i = 1; i < 9; i++) begin
			if (i != 7) begin
				taken(i, 1'b0);
				// software clears only the flags that stay
				if (i >= 3 && i <= 5) xfer(1'b1, irq_pkg::OFS_CLEAR, 32'h1 << i);
				svc_end();
			end
		end
		rd_chk("auto cleared", irq_pkg::OFS_STATUS, 32'h0);
	endtask : s_order
	task automatic s_preempt();
		slow <= 1'b0;
		xfer(1'b1, irq_pkg::OFS_PRIORITY, 32'h100);
		pulse(9'h002);
		taken(1, 1'b0);
		pulse(9'h100);
		taken(8, 1'b1);
		pulse(9'h040);
		quiet(8);
		svc_end();
		quiet(8);
		svc_end();
		taken(6, 1'b0);
		svc_end();
		slow <= 1'b1;
	endtask : s_preempt
	task automatic s_ext();
		xfer(1'b1, irq_pkg::OFS_CTRL, 32'h0);
		xfer(1'b1, irq_pkg::OFS_EXT_SEL, 32'h409);
		xfer(1'b1, irq_pkg::OFS_ENABLE, 32'h81);
		grp_a <= 3'h1;
		wait_on(1'b1, 1'b1);
		rd_chk("group a rise", irq_pkg::OFS_STATUS, 32'h1);
		grp_b <= 3'h4;
		repeat (10) @(posedge hclk);
		rd_chk("group b rise unselected", irq_pkg::OFS_STATUS, 32'h1);
		grp_b <= 3'h0;
		repeat (10) @(posedge hclk);
		rd_chk("group b fall", irq_pkg::OFS_STATUS, 32'h81);
		xfer(1'b1, irq_pkg::OFS_CTRL, 32'h1);
		taken(0, 1'b0);
		svc_end();
		taken(7, 1'b0);
		svc_end();
		grp_a <= 3'h0;
		taken(0, 1'b0);
		svc_end();
		rd_chk("ext auto clear", irq_pkg::OFS_STATUS, 32'h0);
		wait_on(1'b1, 1'b0);
	endtask : s_ext
	// ==========================================
	// verdict
	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset();
		s_gate();
		s_order();
		s_preempt();
		s_ext();
		close_out();
	end
	// whole run is well under 2000 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end
endmodule : nine_source_interrupt_controller_test
